// ### hdl/srwlo_params.svh
/*
 * Constants of the read/write latency option block: link address fields,
 * mode codes, latency adders, timing counts and the controller's register map.
 * Assumes it is included by its bare name from the package only; the modules rely on its macros without including it.
 */
// What this block does
// - Read-to-precharge code 001 gives six clocks.
// - Bus inversion adds two clocks read latency.
// - Parity adds parity delay to read latency.
// - Parity adds parity delay to write latency.
// - Mode 00, or 01 with select high: eight beats.
// - Mode 01 with select low: four-beat chop.
// - Mode 10 chops every burst to four.
// - Termination timing ignores the command delay mode.
// - Write timing only valid after clock loop locks.
// - Added delay enters the read latency sum.
// - Read to precharge spacing: added plus internal.
`ifndef SRWLO_PARAMS_SVH
`define SRWLO_PARAMS_SVH

// Link address fields of the first mode register (bank 0).
`define SRWLO_MR0_BM 1:0
`define SRWLO_MR0_CL 7:4
`define SRWLO_MR0_RTP 11:9
// Link address fields of the extended option register (bank 1).
`define SRWLO_MR1_CWL 3:0
`define SRWLO_MR1_AL 5:4
`define SRWLO_MR1_DBI 6
`define SRWLO_MR1_PAR 7
`define SRWLO_MR1_CAL 10:8
// Link address fields of read and write commands.
`define SRWLO_A_COL 3:0
`define SRWLO_A_AP 10
`define SRWLO_A_BSEL 12

// Burst mode codes.
`define SRWLO_BM_FIXED8 2'h0
`define SRWLO_BM_OTF 2'h1
`define SRWLO_BM_FIXED4 2'h2
`define SRWLO_BEATS8 4'h8
`define SRWLO_BEATS4 4'h4

// Latency adders, in link clocks.
`define SRWLO_AL_CL_M1 2'h1
`define SRWLO_AL_CL_M2 2'h2
`define SRWLO_AL_M1 6'h01
`define SRWLO_AL_M2 6'h02
`define SRWLO_DBI_ADD 6'h02
`define SRWLO_PARITY_DELAY 6'h04
`define SRWLO_RTP_CODE6 3'h1
`define SRWLO_RTP_CODE6_CLK 6'h06
`define SRWLO_RTP_MIN_CLK 6'h04

// Clock loop lock time in the device and controller start-up wait, in link clocks.
`define SRWLO_DLL_LOCK_CLK 5'h10
`define SRWLO_INIT_CLK 5'h18
// Link clocks that the device reset pin stays low while the link clock already runs.
`define SRWLO_RST_CLK 5'h03

// Controller register map, byte addresses.
`define SRWLO_OFS_CMD 8'h00
`define SRWLO_OFS_MODE 8'h04
`define SRWLO_OFS_WDATA0 8'h08
`define SRWLO_OFS_WDATA1 8'h0C
`define SRWLO_OFS_RDATA0 8'h10
`define SRWLO_OFS_RDATA1 8'h14
`define SRWLO_OFS_STATUS 8'h18
// Command register fields.
`define SRWLO_CMD_CODE 2:0
`define SRWLO_CMD_BSEL 3
`define SRWLO_CMD_AP 4
`define SRWLO_CMD_COL 8:5
// Mode register: bits 19:0 are the option set, bit 20 drives termination.
`define SRWLO_MODE_CFG 19:0
`define SRWLO_MODE_TERM 20
`define SRWLO_MODE_RESET 20'h01364
// Status register bits.
`define SRWLO_ST_READY 0
`define SRWLO_ST_BUSY 1
`define SRWLO_ST_RDONE 2

`endif

// ### hdl/srwlo_pkg.sv
/*
 * Types and latency arithmetic shared by both ends of the link.
 * Assumes the constants header is on the include path.
 */
`include "srwlo_params.svh"
package srwlo_pkg;

	// Command codes carried on the link command pins.
	typedef enum logic [2:0] {
		SRWLO_CMD_NOP = 3'h0,
		SRWLO_CMD_MRS = 3'h1,
		SRWLO_CMD_ACT = 3'h2,
		SRWLO_CMD_RD = 3'h3,
		SRWLO_CMD_WR = 3'h4,
		SRWLO_CMD_PRE = 3'h5
	} srwlo_cmd_type;

	// Option set; the layout matches bits 19:0 of the controller mode register.
	typedef struct packed {
		logic [2:0] cal;
		logic par;
		logic bus_inversion;
		logic [1:0] al;
		logic [3:0] write_column_delay;
		logic [3:0] cl;
		logic [2:0] rtp;
		logic [1:0] bm;
	} srwlo_cfg_type;

	localparam srwlo_cfg_type SRWLO_CFG_RESET = srwlo_cfg_type'(`SRWLO_MODE_RESET);

	// Added delay is zero, column latency minus one, or minus two.
	function automatic logic [5:0] srwlo_added_delay(input srwlo_cfg_type c);
		logic [5:0] d;
		d = 6'h00;
		if (c.al == `SRWLO_AL_CL_M1) begin
			d = 6'(c.cl) - `SRWLO_AL_M1;
		end else if (c.al == `SRWLO_AL_CL_M2) begin
			d = 6'(c.cl) - `SRWLO_AL_M2;
		end
		return d;
	endfunction : srwlo_added_delay

	// Read latency: column latency, added delay, parity delay, inversion adder.
	function automatic logic [5:0] srwlo_read_latency(input srwlo_cfg_type c);
		return 6'(c.cl) + srwlo_added_delay(c)
			+ (c.par ? `SRWLO_PARITY_DELAY : 6'h00)
			+ (c.bus_inversion ? `SRWLO_DBI_ADD : 6'h00);
	endfunction : srwlo_read_latency

	// Write delay: write column delay, added delay and parity delay.
	function automatic logic [5:0] srwlo_write_delay(input srwlo_cfg_type c);
		return 6'(c.write_column_delay) + srwlo_added_delay(c)
			+ (c.par ? `SRWLO_PARITY_DELAY : 6'h00);
	endfunction : srwlo_write_delay

	// Beats of one burst; the reserved mode code behaves as eight beats.
	function automatic logic [3:0] srwlo_burst_beats(input logic [1:0] bm, input logic bsel);
		logic [3:0] b;
		b = `SRWLO_BEATS8;
		if (bm == `SRWLO_BM_FIXED4) begin
			b = `SRWLO_BEATS4;
		end else if (bm == `SRWLO_BM_OTF && !bsel) begin
			b = `SRWLO_BEATS4;
		end
		return b;
	endfunction : srwlo_burst_beats

	// Internal read-to-precharge delay; other codes fall back to the minimum.
	function automatic logic [5:0] srwlo_rtp_clocks(input logic [2:0] code);
		return (code == `SRWLO_RTP_CODE6) ? `SRWLO_RTP_CODE6_CLK : `SRWLO_RTP_MIN_CLK;
	endfunction : srwlo_rtp_clocks

endpackage : srwlo_pkg

// ### hdl/srwlo_link_if.sv
/*
 * Link between the memory controller and the memory device.
 * Assumes the controller drives the clock; the two-way data and strobe
 * wires are resolved here from the two enables, low when nobody drives.
 */
`timescale 1ns/1ns
interface srwlo_link_if;
	import srwlo_pkg::*;
	logic ck;
	logic reset_n;
	logic cs_n;
	srwlo_cmd_type cmd;
	logic ba;
	logic [13:0] addr;
	logic term;
	logic [7:0] c_dq_o;
	logic c_dq_oe;
	logic c_dqs_o;
	logic c_dqs_oe;
	logic [7:0] d_dq_o;
	logic d_dq_oe;
	logic d_dqs_o;
	logic d_dqs_oe;
	logic [7:0] dq;
	logic dqs;

	// Wire levels; the controller wins if both ends drive at once.
	assign dq = c_dq_oe ? c_dq_o : (d_dq_oe ? d_dq_o : 8'h00);
	assign dqs = c_dqs_oe ? c_dqs_o : (d_dqs_oe ? d_dqs_o : 1'h0);

	modport ctrl (
		output ck, reset_n, cs_n, cmd, ba, addr, term,
		output c_dq_o, c_dq_oe, c_dqs_o, c_dqs_oe,
		input dq, dqs
	);
	modport dev (
		input ck, reset_n, cs_n, cmd, ba, addr, term, dq, dqs,
		output d_dq_o, d_dq_oe, d_dqs_o, d_dqs_oe
	);
endinterface : srwlo_link_if

// ### hdl/srwlo_sync.sv
/*
 * Two-flop level synchroniser.
 * Assumes the input is a slow level from another clock domain.
 */
`timescale 1ns/1ns
module srwlo_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic meta;
		logic q;
	} srwlo_sync_type;
	srwlo_sync_type s;
	srwlo_sync_type next_s;

	// The first stage feeds only the second stage.
	always_comb begin
		next_s.meta = d;
		next_s.q = s.meta;
	end

	// Synchronous reset to low.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;
endmodule : srwlo_sync

// ### hdl/srwlo_dev.sv
/*
 * Memory device end: decodes commands on the link clock, applies the
 * burst, latency, precharge and command delay options, and reports four
 * status levels into the mclk domain.
 * Assumes the controller forwards the clock and launches pins on its falling half.
 */
`timescale 1ns/1ns
module srwlo_dev (
	srwlo_link_if.dev lk,
	input wire logic mclk,
	input wire logic rstn,
	output logic dev_locked,
	output logic dev_violation,
	output logic dev_term_on,
	output logic dev_bank_open
);
	import srwlo_pkg::*;

	typedef struct packed {
		srwlo_cfg_type cfg;
		logic [6:0] csd;
		logic [4:0] lock_cnt;
		logic locked;
		logic [5:0] rd_cnt;
		logic [3:0] rd_beat;
		logic [3:0] rd_len;
		logic [3:0] rd_col;
		logic [5:0] wr_cnt;
		logic [3:0] wr_beat;
		logic [3:0] wr_len;
		logic [3:0] wr_col;
		logic [5:0] pre_guard;
		logic [5:0] ap_cnt;
		logic bank_open;
		logic violation;
		logic term_on;
		logic [7:0] dq_o;
		logic dq_oe;
		logic [15:0][7:0] mem;
	} srwlo_dev_type;

	localparam srwlo_dev_type DEV_RESET = '{cfg: SRWLO_CFG_RESET, default: '0};

	srwlo_dev_type s;
	srwlo_dev_type next_s;
	logic lrst_n;
	logic [3:0] status;

	// The link reset pin is a foreign level, so it is synchronised to the link clock.
	srwlo_sync u_rst_sync (
		.clk(lk.ck),
		.rstn(1'h1),
		.d(lk.reset_n),
		.q(lrst_n)
	);

	// Command decode and the read, write and precharge timers.
	always_comb begin
		logic take;
		logic [5:0] al;
		logic [3:0] idx;
		srwlo_cmd_type cmd;
		take = 1'h0;
		al = srwlo_added_delay(s.cfg);
		idx = 4'h0;
		cmd = SRWLO_CMD_NOP;
		next_s = s;
		next_s.csd = {s.csd[5:0], !lk.cs_n};
		// With a command delay the pins are read that many clocks after select.
		if (s.cfg.cal == 3'h0) begin
			take = !lk.cs_n;
		end else begin
			take = s.csd[3'(s.cfg.cal - 3'h1)];
		end
		if (take) begin
			cmd = lk.cmd;
		end
		// Termination follows its pin directly, never the delayed command path.
		next_s.term_on = lk.term;
		// Write capture stays off until the clock loop reports lock.
		if (!s.locked) begin
			next_s.lock_cnt = s.lock_cnt + 5'h01;
			next_s.locked = (s.lock_cnt == `SRWLO_DLL_LOCK_CLK - 5'h01);
		end
		if (s.pre_guard != 6'h00) begin
			next_s.pre_guard = s.pre_guard - 6'h01;
		end
		// Auto precharge closes the bank after added plus internal delay.
		if (s.ap_cnt != 6'h00) begin
			next_s.ap_cnt = s.ap_cnt - 6'h01;
			if (s.ap_cnt == 6'h01) begin
				next_s.bank_open = 1'h0;
			end
		end
		// Read data path: beat zero on the clock that completes the latency.
		next_s.dq_oe = 1'h0;
		if (s.rd_cnt != 6'h00) begin
			next_s.rd_cnt = s.rd_cnt - 6'h01;
			if (s.rd_cnt == 6'h01) begin
				next_s.dq_o = s.mem[s.rd_col];
				next_s.dq_oe = 1'h1;
				next_s.rd_beat = 4'h1;
			end
		end else if (s.rd_beat != 4'h0) begin
			if (s.rd_beat == s.rd_len) begin
				next_s.rd_beat = 4'h0;
			end else begin
				idx = s.rd_col + s.rd_beat;
				next_s.dq_o = s.mem[idx];
				next_s.dq_oe = 1'h1;
				next_s.rd_beat = s.rd_beat + 4'h1;
			end
		end
		// Write data path: each beat expects the strobe high at its clock.
		if (s.wr_cnt != 6'h00) begin
			next_s.wr_cnt = s.wr_cnt - 6'h01;
			if (s.wr_cnt == 6'h01) begin
				next_s.mem[s.wr_col] = lk.dq;
				next_s.wr_beat = 4'h1;
				if (!lk.dqs) begin
					next_s.violation = 1'h1;
				end
			end
		end else if (s.wr_beat != 4'h0) begin
			idx = s.wr_col + s.wr_beat;
			next_s.mem[idx] = lk.dq;
			next_s.wr_beat = (s.wr_beat == s.wr_len - 4'h1) ? 4'h0 : s.wr_beat + 4'h1;
			if (!lk.dqs) begin
				next_s.violation = 1'h1;
			end
		end
		// Commands; a read or write that meets its own path busy is dropped.
		unique case (cmd)
			SRWLO_CMD_MRS: begin
				if (!lk.ba) begin
					next_s.cfg.bm = lk.addr[`SRWLO_MR0_BM];
					next_s.cfg.cl = lk.addr[`SRWLO_MR0_CL];
					next_s.cfg.rtp = lk.addr[`SRWLO_MR0_RTP];
				end else begin
					next_s.cfg.write_column_delay = lk.addr[`SRWLO_MR1_CWL];
					next_s.cfg.al = lk.addr[`SRWLO_MR1_AL];
					next_s.cfg.bus_inversion = lk.addr[`SRWLO_MR1_DBI];
					next_s.cfg.par = lk.addr[`SRWLO_MR1_PAR];
					next_s.cfg.cal = lk.addr[`SRWLO_MR1_CAL];
				end
			end
			SRWLO_CMD_ACT: begin
				next_s.bank_open = 1'h1;
			end
			SRWLO_CMD_RD: begin
				if (s.rd_cnt == 6'h00 && s.rd_beat == 4'h0) begin
					next_s.rd_cnt = srwlo_read_latency(s.cfg);
					next_s.rd_len = srwlo_burst_beats(s.cfg.bm, lk.addr[`SRWLO_A_BSEL]);
					next_s.rd_col = lk.addr[`SRWLO_A_COL];
					next_s.pre_guard = al + srwlo_rtp_clocks(s.cfg.rtp);
					if (lk.addr[`SRWLO_A_AP]) begin
						next_s.ap_cnt = al + srwlo_rtp_clocks(s.cfg.rtp);
					end
				end
			end
			SRWLO_CMD_WR: begin
				if (s.locked && s.wr_cnt == 6'h00 && s.wr_beat == 4'h0) begin
					next_s.wr_cnt = srwlo_write_delay(s.cfg);
					next_s.wr_len = srwlo_burst_beats(s.cfg.bm, lk.addr[`SRWLO_A_BSEL]);
					next_s.wr_col = lk.addr[`SRWLO_A_COL];
				end
			end
			SRWLO_CMD_PRE: begin
				// An early precharge is still obeyed but is recorded.
				if (s.pre_guard != 6'h00) begin
					next_s.violation = 1'h1;
				end
				next_s.bank_open = 1'h0;
				next_s.ap_cnt = 6'h00;
			end
			default: begin
			end
		endcase
	end

	// Link-clock state; reset follows the synchronised link reset pin.
	always_ff @(posedge lk.ck) begin
		if (!lrst_n) begin
			s <= DEV_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Read data and its strobe leave together; the strobe marks each beat.
	assign lk.d_dq_o = s.dq_o;
	assign lk.d_dq_oe = s.dq_oe;
	assign lk.d_dqs_o = s.dq_oe;
	assign lk.d_dqs_oe = s.dq_oe;

	// Status levels cross into the mclk domain one bit at a time.
	for (genvar i = 0; i < 4; i++) begin : g_status
		srwlo_sync u_sync (
			.clk(mclk),
			.rstn(rstn),
			.d(i == 0 ? s.locked : i == 1 ? s.violation : i == 2 ? s.term_on : s.bank_open),
			.q(status[i])
		);
	end

	assign dev_locked = status[0];
	assign dev_violation = status[1];
	assign dev_term_on = status[2];
	assign dev_bank_open = status[3];
endmodule : srwlo_dev

// ### hdl/srwlo_ctrl.sv
/*
 * Memory controller end: an APB slave on mclk whose registers order
 * commands; it divides mclk by two into the link clock and drives the link.
 * Assumes software writes the mode register and then issues a mode command.
 */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module srwlo_ctrl (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	srwlo_link_if.ctrl lk
);
	import srwlo_pkg::*;

	typedef enum logic [2:0] {
		ST_INIT = 3'h0,
		ST_IDLE = 3'h1,
		ST_CS = 3'h2,
		ST_WR_WAIT = 3'h3,
		ST_WR_BURST = 3'h4,
		ST_RD_WAIT = 3'h5
	} srwlo_ctrl_st_type;

	typedef struct packed {
		srwlo_ctrl_st_type st;
		srwlo_cfg_type cfg;
		logic term;
		logic [63:0] wdata;
		logic [63:0] rdata;
		srwlo_cmd_type code;
		logic bsel;
		logic ap;
		logic [3:0] col;
		logic phase;
		logic [5:0] cnt;
		logic [3:0] beat;
		logic [3:0] len;
		logic [4:0] init_cnt;
		logic [2:0] lcal;
		logic rd_done;
		logic ck;
		logic rst_o;
		logic cs_n;
		srwlo_cmd_type cmd_o;
		logic ba;
		logic [13:0] addr;
		logic [7:0] dq_o;
		logic dq_oe;
		logic dqs_m;
		logic dqs_s;
		logic [7:0] dq_m;
		logic [7:0] dq_s;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} srwlo_ctrl_type;

	localparam srwlo_ctrl_type CTRL_RESET = '{
		st: ST_INIT, cfg: SRWLO_CFG_RESET, code: SRWLO_CMD_NOP, cmd_o: SRWLO_CMD_NOP,
		cs_n: 1'h1, default: '0};

	srwlo_ctrl_type s;
	srwlo_ctrl_type next_s;

	// Register access, link clock divider and command sequencing.
	always_comb begin
		logic setup;
		logic wr_acc;
		logic tick;
		logic [13:0] a;
		logic [31:0] rd;
		setup = psel && !penable;
		wr_acc = psel && penable && s.pready && pwrite;
		tick = s.ck;
		a = 14'h0000;
		rd = 32'h00000000;
		next_s = s;
		next_s.ck = !s.ck;
		// Device pins pass two flops before use.
		next_s.dqs_m = lk.dqs;
		next_s.dqs_s = s.dqs_m;
		next_s.dq_m = lk.dq;
		next_s.dq_s = s.dq_m;
		// The answer is ready in the first access cycle.
		unique case (paddr)
			`SRWLO_OFS_CMD: rd = {23'h000000, s.col, s.ap, s.bsel, s.code};
			`SRWLO_OFS_MODE: rd = {11'h000, s.term, s.cfg};
			`SRWLO_OFS_WDATA0: rd = s.wdata[31:0];
			`SRWLO_OFS_WDATA1: rd = s.wdata[63:32];
			`SRWLO_OFS_RDATA0: rd = s.rdata[31:0];
			`SRWLO_OFS_RDATA1: rd = s.rdata[63:32];
			`SRWLO_OFS_STATUS: rd = {29'h00000000, s.rd_done, s.st != ST_IDLE && s.st != ST_INIT,
				s.st != ST_INIT};
			default: rd = 32'h00000000;
		endcase
		next_s.pready = setup;
		next_s.pslverr = setup && !(paddr <= `SRWLO_OFS_STATUS && paddr[1:0] == 2'h0);
		next_s.prdata = (setup && !pwrite) ? rd : 32'h00000000;
		if (wr_acc) begin
			unique case (paddr)
				`SRWLO_OFS_MODE: begin
					next_s.cfg = srwlo_cfg_type'(pwdata[`SRWLO_MODE_CFG]);
					next_s.term = pwdata[`SRWLO_MODE_TERM];
				end
				`SRWLO_OFS_WDATA0: next_s.wdata[31:0] = pwdata;
				`SRWLO_OFS_WDATA1: next_s.wdata[63:32] = pwdata;
				`SRWLO_OFS_CMD: begin
					// A command while busy or before start-up is dropped.
					if (s.st == ST_IDLE) begin
						next_s.code = srwlo_cmd_type'(pwdata[`SRWLO_CMD_CODE]);
						next_s.bsel = pwdata[`SRWLO_CMD_BSEL];
						next_s.ap = pwdata[`SRWLO_CMD_AP];
						next_s.col = pwdata[`SRWLO_CMD_COL];
						next_s.phase = 1'h0;
						next_s.cnt = 6'h00;
						next_s.rd_done = 1'h0;
						next_s.st = ST_CS;
					end
				end
				default: begin
				end
			endcase
		end
		// Link pins other than termination change only on the falling half so the device sees them settled.
		if (tick) begin
			next_s.cs_n = 1'h1;
			next_s.cmd_o = SRWLO_CMD_NOP;
			unique case (s.st)
				ST_INIT: begin
					// No command goes out before the device clock loop can be locked.
					next_s.init_cnt = s.init_cnt + 5'h01;
					// The device reset pin rises on a falling half, after the link clock has
					// run a few periods, so the device synchroniser sees it low first.
					if (s.init_cnt == `SRWLO_RST_CLK) begin
						next_s.rst_o = 1'h1;
					end
					if (s.init_cnt == `SRWLO_INIT_CLK) begin
						next_s.st = ST_IDLE;
					end
				end
				ST_IDLE: begin
				end
				ST_CS: begin
					// Select first, pins after the delay that the device holds now; a mode
					// command that changes the delay still goes out under the old one.
					next_s.cs_n = (s.cnt != 6'h00);
					if (s.cnt == 6'(s.lcal)) begin
						if (s.code == SRWLO_CMD_MRS && !s.phase) begin
							a[`SRWLO_MR0_BM] = s.cfg.bm;
							a[`SRWLO_MR0_CL] = s.cfg.cl;
							a[`SRWLO_MR0_RTP] = s.cfg.rtp;
						end else if (s.code == SRWLO_CMD_MRS) begin
							a[`SRWLO_MR1_CWL] = s.cfg.write_column_delay;
							a[`SRWLO_MR1_AL] = s.cfg.al;
							a[`SRWLO_MR1_DBI] = s.cfg.bus_inversion;
							a[`SRWLO_MR1_PAR] = s.cfg.par;
							a[`SRWLO_MR1_CAL] = s.cfg.cal;
						end else begin
							a[`SRWLO_A_COL] = s.col;
							a[`SRWLO_A_AP] = s.ap;
							a[`SRWLO_A_BSEL] = s.bsel;
						end
						next_s.cmd_o = s.code;
						next_s.ba = s.phase;
						next_s.addr = a;
						if (s.code == SRWLO_CMD_MRS && s.phase) begin
							next_s.lcal = s.cfg.cal;
						end
						next_s.beat = 4'h0;
						next_s.len = srwlo_burst_beats(s.cfg.bm, s.bsel);
						next_s.cnt = srwlo_write_delay(s.cfg);
						if (s.code == SRWLO_CMD_MRS && !s.phase) begin
							next_s.phase = 1'h1;
							next_s.cnt = 6'h00;
						end else if (s.code == SRWLO_CMD_WR) begin
							next_s.st = ST_WR_WAIT;
						end else if (s.code == SRWLO_CMD_RD) begin
							next_s.st = ST_RD_WAIT;
						end else begin
							next_s.st = ST_IDLE;
						end
					end else begin
						next_s.cnt = s.cnt + 6'h01;
					end
				end
				ST_WR_WAIT: begin
					// Beat zero lands on the device clock that ends the write delay.
					if (s.cnt == 6'h01) begin
						next_s.dq_o = s.wdata[7:0];
						next_s.dq_oe = 1'h1;
						next_s.beat = 4'h1;
						next_s.st = ST_WR_BURST;
					end else begin
						next_s.cnt = s.cnt - 6'h01;
					end
				end
				ST_WR_BURST: begin
					if (s.beat == s.len) begin
						next_s.dq_oe = 1'h0;
						next_s.st = ST_IDLE;
					end else begin
						next_s.dq_o = s.wdata[8 * s.beat +: 8];
						next_s.beat = s.beat + 4'h1;
					end
				end
				ST_RD_WAIT: begin
					// Each strobed beat is held two mclk cycles, so one tick takes it once.
					if (s.dqs_s) begin
						next_s.rdata[8 * s.beat +: 8] = s.dq_s;
						next_s.beat = s.beat + 4'h1;
						if (s.beat + 4'h1 == s.len) begin
							next_s.rd_done = 1'h1;
							next_s.st = ST_IDLE;
						end
					end
				end
				default: begin
					next_s.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign lk.ck = s.ck;
	assign lk.reset_n = s.rst_o;
	assign lk.cs_n = s.cs_n;
	assign lk.cmd = s.cmd_o;
	assign lk.ba = s.ba;
	assign lk.addr = s.addr;
	assign lk.term = s.term;
	assign lk.c_dq_o = s.dq_o;
	assign lk.c_dq_oe = s.dq_oe;
	assign lk.c_dqs_o = s.dq_oe;
	assign lk.c_dqs_oe = s.dq_oe;
endmodule : srwlo_ctrl

// ### tb/srwlo_assertions.sv
/*
 * Link checker: read and write latency, burst length and write strobe.
 * Assumes it sees the link signals beside the interface joining both ends.
 */
`timescale 1ns/1ns
module srwlo_assertions (
	input wire logic ck,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire srwlo_pkg::srwlo_cmd_type cmd,
	input wire logic ba,
	input wire logic [13:0] addr,
	input wire logic c_dq_oe,
	input wire logic c_dqs_oe,
	input wire logic d_dq_oe,
	input wire logic dqs
);
	import srwlo_pkg::*;
	logic [13:0] m0, m1;
	logic [7:0] csh;
	logic [5:0] n, bt;
	logic bs;
	// A command counts where chip select was low the programmed delay earlier.
	wire [8:0] cq = {csh, cs_n};
	wire tk = !cq[m1[10:8]];
	wire go = tk && (cmd == SRWLO_CMD_RD || cmd == SRWLO_CMD_WR);
	wire [5:0] cl = {2'h0, m0[7:4]};
	wire [5:0] ad = m1[5:4] == 2'h1 ? cl - 6'h01 : m1[5:4] == 2'h2 ? cl - 6'h02 : 6'h00;
	wire [5:0] pd = m1[7] ? 6'h04 : 6'h00;
	wire [5:0] rl = cl + ad + pd + (m1[6] ? 6'h02 : 6'h00);
	wire [5:0] wl = {2'h0, m1[3:0]} + ad + pd;
	wire [5:0] bl = m0[1:0] == 2'h2 || (m0[1:0] == 2'h1 && !bs) ? 6'h04 : 6'h08;
	// Option words, select history, clocks since a transfer and beats seen.
	always_ff @(posedge ck) begin
		if (!reset_n) begin
			m0 <= '0;
			m1 <= '0;
			csh <= '1;
			n <= '0;
			bt <= '0;
			bs <= 1'b0;
		end else begin
			csh <= cq[7:0];
			m0 <= (tk && cmd == SRWLO_CMD_MRS && !ba) ? addr : m0;
			m1 <= (tk && cmd == SRWLO_CMD_MRS && ba) ? addr : m1;
			bs <= go ? addr[12] : bs;
			n <= go ? 6'h01 : (n == 6'h3F ? n : n + 6'h01);
			bt <= (d_dq_oe || c_dq_oe) ? bt + 6'h01 : 6'h00;
		end
	end
	default clocking @(posedge ck); endclocking
	default disable iff (!reset_n);
	AST_RD_LAT_ADD: assert property ($rose(d_dq_oe) && m1[5:4] == 2'h2 |-> n == rl + 6'h01)
		else $error("read latency with added delay");
	AST_RD_LAT_PAR: assert property ($rose(d_dq_oe) && m1[7] |-> n == rl + 6'h01)
		else $error("read latency with parity");
	AST_RD_LAT_INV: assert property ($rose(d_dq_oe) && m1[6] |-> n == rl + 6'h01)
		else $error("read latency with inversion");
	AST_RD_LAT_CAL: assert property ($rose(d_dq_oe) && m1[10:8] != 3'h0 |-> n == rl + 6'h01)
		else $error("read latency with command delay");
	AST_WR_LAT: assert property ($rose(c_dq_oe) |-> n == wl)
		else $error("write delay");
	AST_BURST8: assert property ($fell(d_dq_oe || c_dq_oe) && bl == 6'h08 |-> bt == 6'h08)
		else $error("eight beat burst length");
	AST_CHOP_OTF: assert property ($fell(d_dq_oe || c_dq_oe) && m0[1:0] == 2'h1 |-> bt == bl)
		else $error("per command burst length");
	AST_CHOP_FIX: assert property ($fell(d_dq_oe || c_dq_oe) && m0[1:0] == 2'h2 |-> bt == 6'h04)
		else $error("fixed chop length");
	AST_WR_STROBE: assert property (c_dq_oe |-> c_dqs_oe && dqs)
		else $error("write beat without strobe");
	cover property (go && cmd == SRWLO_CMD_WR);
	cover property ($fell(d_dq_oe) && bt == 6'h04);
	cover property ($rose(d_dq_oe) && m1[10:8] != 3'h0);
endmodule : srwlo_assertions

// ### tb/tb.sv
/*
 * Top testbench: APB driver, both link ends and the link checker.
 * Assumes the design files are compiled first; mclk runs at 10 MHz.
 */
`timescale 1ns/1ns
module tb;
	import srwlo_pkg::*;
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic locked, viol, term_on, bank_open;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, d0, d1, md;
	logic [10:0] t;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	// Per test: select, termination, command delay, parity, inversion, added delay, mode.
	logic [10:0] tab [5] = '{11'h000, 11'h409, 11'h021, 11'h412, 11'h6C0};
	srwlo_link_if lk();
	srwlo_ctrl u_srwlo_ctrl (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lk(lk.ctrl));
	srwlo_dev u_srwlo_dev (.lk(lk.dev), .mclk(mclk), .rstn(rstn), .dev_locked(locked),
		.dev_violation(viol), .dev_term_on(term_on), .dev_bank_open(bank_open));
	srwlo_assertions u_srwlo_assertions (.ck(lk.ck), .reset_n(lk.reset_n), .cs_n(lk.cs_n),
		.cmd(lk.cmd), .ba(lk.ba), .addr(lk.addr), .c_dq_oe(lk.c_dq_oe),
		.c_dqs_oe(lk.c_dqs_oe), .d_dq_oe(lk.d_dq_oe), .dqs(lk.dqs));
	// Clock generator.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// The tests need about a thousand cycles, so this only trips on a hang.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			mismatches++;
			close_out();
		end
	end
	// One transfer; the request stands until pready is seen, then one idle cycle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk32
	task automatic chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask : chk1
	// Polls one status bit; a hang is cut by the cycle ceiling.
	task automatic wait_st(input int b, input logic v);
		do apb(1'b0, 8'h18, 32'h0); while (rd[b] !== v);
	endtask : wait_st
	task automatic cmd(input logic [2:0] c, input logic bs, input logic ap, input logic [3:0] col);
		apb(1'b1, 8'h00, {23'h0, col, ap, bs, c});
		wait_st(1, 1'b0);
	endtask : cmd
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	// Main sequence: reset, one write and read per option set, then precharge.
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		apb(1'b0, 8'h04, 32'h0);
		chk32(rd, 32'h00001364);
		apb(1'b0, 8'h1C, 32'h0);
		chk1(er, 1'b1);
		wait_st(0, 1'b1);
		chk1(locked, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			t = tab[i];
			d0 = 32'h03020100 + 32'h10101010 * i;
			d1 = d0 + 32'h04040404;
			md = {11'h0, t[9], t[8:6], t[5], t[4], t[3:2], 4'h9, 4'hB, 3'h1, t[1:0]};
			apb(1'b1, 8'h04, md);
			cmd(SRWLO_CMD_MRS, 1'b0, 1'b0, 4'h0);
			cmd(SRWLO_CMD_ACT, 1'b0, 1'b0, 4'h0);
			apb(1'b1, 8'h08, d0);
			apb(1'b1, 8'h0C, d1);
			cmd(SRWLO_CMD_WR, t[10], 1'b0, 4'(3 * i));
			cmd(SRWLO_CMD_RD, t[10], 1'b0, 4'(3 * i));
			wait_st(2, 1'b1);
			apb(1'b0, 8'h10, 32'h0);
			chk32(rd, d0);
			apb(1'b0, 8'h14, 32'h0);
			if (t[1] == 1'b0 && (t[0] == 1'b0 || t[10])) begin
				chk32(rd, d1);
			end
			cmd(SRWLO_CMD_PRE, 1'b0, 1'b0, 4'h0);
			$display("test %0d done", i);
		end
		chk1(term_on, 1'b1);
		cmd(SRWLO_CMD_ACT, 1'b0, 1'b0, 4'h0);
		// The bank state needs a link clock and two mclk flops to reach the status pin.
		repeat (4) @(posedge mclk);
		chk1(bank_open, 1'b1);
		cmd(SRWLO_CMD_RD, 1'b0, 1'b1, 4'h0);
		wait_st(2, 1'b1);
		chk1(bank_open, 1'b0);
		chk1(viol, 1'b0);
		$display("test precharge done");
		close_out();
	end
endmodule : tb
